// ===== rtl/sbc_defs.svh
// constants for the single/block cycle bus ends
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
`define SBC_ADR_W 16
`define SBC_DAT_W 32
`define SBC_SEL_W 4
`define SBC_TAG_W 4
`define SBC_MEM_DEPTH 16
`define SBC_MEM_AW 4
`define SBC_BUF_DEPTH 2
`endif

// ===== rtl/sbc_pkg.sv
// types shared by the bus ends
`include "sbc_defs.svh"
package sbc_pkg;
   typedef logic [`SBC_ADR_W-1:0] sbc_adr_t;
   typedef logic [`SBC_DAT_W-1:0] sbc_dat_t;
   typedef logic [`SBC_SEL_W-1:0] sbc_sel_t;
   typedef logic [`SBC_TAG_W-1:0] sbc_tag_t;
   typedef enum logic [2:0] {
      SBC_IDLE = 3'b001,
      SBC_HOLD = 3'b010,
      SBC_XFER = 3'b100
   } sbc_mst_e;
endpackage : sbc_pkg

// ===== rtl/sbc_if.sv
// bus signals between master and slave ends
`timescale 1ns/1ps
`include "sbc_defs.svh"
interface sbc_if (
   input wire logic clk,
   input wire logic rst
);
   logic cyc;
   logic stb;
   logic we;
   sbc_pkg::sbc_adr_t adr;
   sbc_pkg::sbc_sel_t sel;
   sbc_pkg::sbc_dat_t dat_m2s;
   sbc_pkg::sbc_dat_t dat_s2m;
   sbc_pkg::sbc_tag_t tag_m2s;
   sbc_pkg::sbc_tag_t tag_s2m;
   logic ack;
   logic err;
   logic rty;
   modport master (input clk, rst, ack, err, rty, dat_s2m, tag_s2m,
      output cyc, stb, we, adr, sel, dat_m2s, tag_m2s);
   modport slave (input clk, rst, cyc, stb, we, adr, sel, dat_m2s, tag_m2s,
      output ack, err, rty, dat_s2m, tag_s2m);
endinterface : sbc_if

// ===== rtl/sbc_buf.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_buf #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_ff [`SBC_BUF_DEPTH];
   logic rd_ff;
   logic wr_ff;
   logic [1:0] cnt_ff;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_ff != 2'd2);
   assign out_valid = (cnt_ff != 2'd0);
   assign out_data = mem_ff[rd_ff];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         cnt_ff <= 2'd0;
      end else begin
         if (push) wr_ff <= ~wr_ff;
         if (pop) rd_ff <= ~rd_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem_ff[wr_ff] <= in_data;
   end
endmodule : sbc_buf

// ===== rtl/sbc_slave.sv
// slave end: small memory with combinational ack and read-data buffer
// Summary of operation
// - master reads with we low, cyc, stb
// - master writes with we high, cyc, stb
// - slave drives valid read data with ack
// - slave stores write data on acked edge
// - slave may add unbounded wait states
// - master takes read data on acked edge
// - single cycle ends dropping stb, cyc together
// - cyc held high through whole block
// - cyc may lead or trail stb
// - one transfer per clock in blocks; reads here ack only every second clock, as the buffer refills from empty
// - master inserts waits by dropping stb
// - ack falls whenever stb is low
// - slave may stall between block transfers
// - block ends dropping stb, cyc at last ack
// - cyc asserted by first acked edge
// - supported cycle types follow their timing
// - never more than one terminator at once
// - terminators follow stb combinationally
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_slave (
   // bus
   sbc_if.slave bus,
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // user side
   input wire logic stall,
   output logic wr_seen_ff,
   output logic [`SBC_ADR_W-1:0] wr_adr_ff
);
   sbc_pkg::sbc_dat_t mem_ff [`SBC_MEM_DEPTH];
   logic rd_valid;
   logic rd_ready;
   sbc_pkg::sbc_dat_t rd_data;
   logic in_ready;
   wire [`SBC_MEM_AW-1:0] idx = bus.adr[`SBC_MEM_AW+1:2];
   wire req = bus.cyc && bus.stb;
   // reads go through the buffer so a read word is fetched before it is acked
   wire rd_fill = req && !bus.we && !stall;
   wire wr_ok = req && bus.we && !stall;
   assign rd_ready = req && !bus.we && !stall;
   // ack rides on stb combinationally; only a read word already buffered may answer
   assign bus.ack = wr_ok || (rd_ready && rd_valid);
   assign bus.err = 1'b0;
   assign bus.rty = 1'b0;
   assign bus.dat_s2m = rd_data;
   assign bus.tag_s2m = bus.tag_m2s;
   // buffer is refilled only from an empty state, so stale words never answer
   wire fill_now = rd_fill && !rd_valid && in_ready;
   sbc_buf #(.W(`SBC_DAT_W)) u_rdbuf (
      .clk(clk),
      .rstn(rstn),
      .in_valid(fill_now),
      .in_ready(in_ready),
      .in_data(mem_ff[idx]),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );
   always_ff @(posedge clk) begin
      if (wr_ok) begin
         for (int b = 0; b < `SBC_SEL_W; b++) begin
            if (bus.sel[b]) mem_ff[idx][8*b +: 8] <= bus.dat_m2s[8*b +: 8];
         end
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_seen_ff <= 1'b0;
         wr_adr_ff <= '0;
      end else begin
         wr_seen_ff <= wr_ok;
         if (wr_ok) wr_adr_ff <= bus.adr;
      end
   end
endmodule : sbc_slave

// ===== rtl/sbc_master.sv
// master end: runs single or block cycles from a user request
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_master (
   // bus
   sbc_if.master bus,
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // user request
   input wire logic go,
   input wire logic go_we,
   input wire logic [`SBC_ADR_W-1:0] go_adr,
   input wire logic [3:0] go_len,
   input wire logic [`SBC_DAT_W-1:0] go_dat,
   input wire logic pause,
   // user answer
   output logic busy_ff,
   output logic rd_valid_ff,
   output logic [`SBC_DAT_W-1:0] rd_data_ff,
   output logic [`SBC_TAG_W-1:0] rd_tag_ff
);
   sbc_pkg::sbc_mst_e st_ff;
   logic cyc_ff;
   logic stb_ff;
   logic we_ff;
   logic [`SBC_ADR_W-1:0] adr_ff;
   logic [3:0] left_ff;
   logic [`SBC_DAT_W-1:0] dat_ff;
   assign bus.cyc = cyc_ff;
   assign bus.stb = stb_ff;
   assign bus.we = we_ff;
   assign bus.adr = adr_ff;
   assign bus.sel = '1;
   assign bus.dat_m2s = dat_ff;
   assign bus.tag_m2s = adr_ff[`SBC_TAG_W-1:0];
   wire done = stb_ff && (bus.ack || bus.err || bus.rty);
   wire last = done && (left_ff == 4'd0);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= sbc_pkg::SBC_IDLE;
         {cyc_ff, stb_ff, we_ff, busy_ff, rd_valid_ff} <= '0;
         adr_ff <= '0;
         left_ff <= '0;
         dat_ff <= '0;
         rd_data_ff <= '0;
         rd_tag_ff <= '0;
      end else begin
         rd_valid_ff <= done && !we_ff && bus.ack;
         if (done && !we_ff) begin
            rd_data_ff <= bus.dat_s2m;
            rd_tag_ff <= bus.tag_s2m;
         end
         case (st_ff)
            sbc_pkg::SBC_IDLE: begin
               if (go) begin
                  st_ff <= sbc_pkg::SBC_XFER;
                  {cyc_ff, stb_ff, busy_ff} <= 3'b111;
                  we_ff <= go_we;
                  adr_ff <= go_adr;
                  left_ff <= go_len;
                  dat_ff <= go_dat;
               end
            end
            sbc_pkg::SBC_XFER: begin
               if (last) begin
                  st_ff <= sbc_pkg::SBC_IDLE;
                  {cyc_ff, stb_ff, busy_ff} <= 3'b000;
               end else if (done) begin
                  adr_ff <= adr_ff + `SBC_ADR_W'(4);
                  dat_ff <= dat_ff + `SBC_DAT_W'(1);
                  left_ff <= left_ff - 4'd1;
                  if (pause) begin
                     stb_ff <= 1'b0;
                     st_ff <= sbc_pkg::SBC_HOLD;
                  end
               end
            end
            sbc_pkg::SBC_HOLD: begin
               if (!pause) begin
                  stb_ff <= 1'b1;
                  st_ff <= sbc_pkg::SBC_XFER;
               end
            end
            default: st_ff <= sbc_pkg::SBC_IDLE;
         endcase
      end
   end
endmodule : sbc_master

// ===== sim/sbc_properties.sv
// checker for the bus between master and slave ends
`timescale 1ns/1ps
module sbc_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // master side
   input wire logic cyc,
   input wire logic stb,
   input wire logic we,
   input wire sbc_pkg::sbc_adr_t adr,
   input wire sbc_pkg::sbc_dat_t dat_m2s,
   input wire sbc_pkg::sbc_tag_t tag_m2s,
   // slave side
   input wire logic ack,
   input wire logic err,
   input wire logic rty,
   input wire sbc_pkg::sbc_tag_t tag_s2m
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_ack_needs_stb: assert property (ack |-> stb)
      else $error("ack without strobe");
   a_one_terminator: assert property ($onehot0({ack, err, rty}))
      else $error("several terminators");
   a_stb_in_cyc: assert property (stb |-> cyc)
      else $error("strobe outside cycle");
   a_ack_in_cyc: assert property (ack |-> cyc)
      else $error("ack outside cycle");
   a_hold_until_ack: assert property (stb && !ack |=> stb && $stable(adr) && $stable(we)
      && $stable(dat_m2s) && $stable(tag_m2s))
      else $error("request changed before ack");
   a_ack_bounded: assert property ($rose(stb) |-> ##[0:12] ack)
      else $error("no ack in time");
   a_end_at_ack: assert property ($fell(cyc) |-> $past(ack) && !stb)
      else $error("cycle ended off ack");
   a_tag_echo: assert property (stb |-> tag_s2m == tag_m2s)
      else $error("tag not echoed");
endmodule : sbc_properties

// ===== sim/soc_bus_single_block_cycles_tb.sv
// bench for the single and block cycle bus ends
`timescale 1ns/1ps
`include "sbc_defs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module soc_bus_single_block_cycles_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic stall = 1'b0;
   logic go = 1'b0;
   logic go_we = 1'b0;
   logic [`SBC_ADR_W-1:0] go_adr = '0;
   logic [3:0] go_len = '0;
   logic [`SBC_DAT_W-1:0] go_dat = '0;
   logic pause = 1'b0;
   logic busy_ff, rd_valid_ff, wr_seen_ff;
   logic [`SBC_ADR_W-1:0] wr_adr_ff;
   logic [`SBC_DAT_W-1:0] rd_data_ff;
   logic [`SBC_TAG_W-1:0] rd_tag_ff;
   sbc_pkg::sbc_dat_t mem [16];
   int failures = 0;
   int n_tests = 0;
   initial forever #20 clk = ~clk;
   sbc_if bus (.clk(clk), .rst(!rstn));
   sbc_slave i_sbc_slave (.bus(bus), .clk(clk), .rstn(rstn), .stall(stall),
      .wr_seen_ff(wr_seen_ff), .wr_adr_ff(wr_adr_ff));
   sbc_master i_sbc_master (.bus(bus), .clk(clk), .rstn(rstn), .go(go), .go_we(go_we),
      .go_adr(go_adr), .go_len(go_len), .go_dat(go_dat), .pause(pause), .busy_ff(busy_ff),
      .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff), .rd_tag_ff(rd_tag_ff));
   sbc_properties i_sbc_properties (.clk(clk), .rstn(rstn), .cyc(bus.cyc), .stb(bus.stb),
      .we(bus.we), .adr(bus.adr), .dat_m2s(bus.dat_m2s), .tag_m2s(bus.tag_m2s),
      .ack(bus.ack), .err(bus.err), .rty(bus.rty), .tag_s2m(bus.tag_s2m));
   task automatic tally_and_finish();
      if (failures == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // one cycle from go to idle; sp and pp add slave and master wait states
   task automatic run(input logic we, input sbc_pkg::sbc_adr_t a, input logic [3:0] len,
         input sbc_pkg::sbc_dat_t d, input logic sp, input logic pp);
      int n;
      n = 0;
      for (int j = 0; j <= len; j++) begin
         if (we) mem[4'(a[5:2] + j)] = d + j;
      end
      go_we = we;
      go_adr = a;
      go_len = len;
      go_dat = d;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (int k = 0; k < 200; k++) begin
         @(negedge clk);
         stall = sp & k[0];
         pause = pp & k[1];
         if (rd_valid_ff === 1'b1) begin
            `CHK("rd_data", mem[4'(a[5:2] + n)], rd_data_ff)
            `CHK("rd_tag", 4'(a + 16'(4 * n)), rd_tag_ff)
            n++;
         end
         if (wr_seen_ff === 1'b1) begin
            `CHK("wr_adr", a + 16'(4 * n), wr_adr_ff)
            n++;
         end
         if (busy_ff === 1'b0 && n > len) break;
      end
      `CHK("count", len + 1, n)
      stall = 1'b0;
      pause = 1'b0;
      // a hung cycle leaves busy up: stop here rather than stack more requests
      if (busy_ff !== 1'b0) begin
         failures++;
         tally_and_finish();
      end
   endtask : run
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      run(1'b1, 16'h0000, 4'h0, 32'h1234_5678, 1'b0, 1'b0);
      run(1'b0, 16'h0000, 4'h0, 32'h0000_0000, 1'b0, 1'b0);
      run(1'b1, 16'h0000, 4'hf, 32'ha000_0000, 1'b0, 1'b0);
      run(1'b0, 16'h0000, 4'hf, 32'h0000_0000, 1'b1, 1'b0);
      run(1'b1, 16'h0024, 4'h3, 32'h5500_00f0, 1'b1, 1'b1);
      run(1'b0, 16'h0024, 4'h3, 32'h0000_0000, 1'b1, 1'b1);
      tally_and_finish();
   end
endmodule : soc_bus_single_block_cycles_tb
